// ==== hw/ifsc_params.svh ====
/*
 * Constants of the IF synthesizer control block: control-bit codes,
 * field positions, reset values and the word width.
 * Assumes inclusion by bare name from the package alone.
 */
`ifndef IFSC_PARAMS_SVH
`define IFSC_PARAMS_SVH

`define IFSC_WORD_W      24
`define IFSC_RST_WORD    24'h000000
`define IFSC_ADDR_RF_INT 3'h0
`define IFSC_ADDR_RF_FRC 3'h1
`define IFSC_ADDR_RF_CTL 3'h2
`define IFSC_ADDR_MASTER 3'h3
`define IFSC_ADDR_IF_N   3'h4
`define IFSC_ADDR_IF_REF 3'h5
`define IFSC_ADDR_IF_CTL 3'h6
// if control word
`define IFSC_IFC_CNT_RST 3
`define IFSC_IFC_CP_TS   4
`define IFSC_IFC_PD      5
`define IFSC_IFC_POL     7
`define IFSC_IFC_CUR     10:8
`define IFSC_IFC_RS_A    11
`define IFSC_IFC_TEST    13:12
`define IFSC_IFC_RS_B    14
`define IFSC_IFC_RS_C    15
// if reference-divider word
`define IFSC_IFR_DIV     17:3
`define IFSC_IFR_DBL     18
// if n-divider word
`define IFSC_IFN_A       8:3
`define IFSC_IFN_B       21:9
`define IFSC_IFN_P       23:22
// rf words
`define IFSC_RF_INT      14:3
`define IFSC_RF_FRAC     14:3
`define IFSC_RF_MOD      22:11
`define IFSC_RF_RDIV     20:17
`define IFSC_RF_DBL      21

`endif

// ==== hw/ifsc_pkg.sv ====
/*
 * Types shared by the IF synthesizer control block.
 * Assumes the constants header sits beside it.
 */
`include "ifsc_params.svh"

package ifsc_pkg;

    // decoded if control word fields
    typedef struct packed {
        logic [1:0] test_mode;
        logic       resync_en;
        logic [2:0] cp_current;
        logic       pd_polarity;
        logic       power_down;
        logic       cp_three_state;
        logic       counter_reset;
    } ifsc_if_ctrl_t;

    typedef enum logic [0:0] {
        IFSC_RS_IDLE,
        IFSC_RS_COUNT
    } ifsc_rs_state_t;

endpackage

// ==== hw/ifsc_serial_rx.sv ====
/*
 * Three-wire serial input register: shifts on clock rises, latches on
 * strobe rise. Assumes pins are asynchronous and the serial clock is
 * slower than a quarter of sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module ifsc_serial_rx import ifsc_pkg::*; #(
    parameter int WORD_W = `IFSC_WORD_W
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // pins
    input  wire logic              sclk_pin,
    input  wire logic              serial_data_pin,
    input  wire logic              latch_strobe,
    // latched word
    output logic [WORD_W-1:0]      word,
    output logic                   word_valid
);

    logic [2:0]        sclk_s;
    logic [1:0]        data_s;
    logic [2:0]        le_s;
    logic [WORD_W-1:0] shift;

    wire sclk_rise = sclk_s[1] & ~sclk_s[2];
    wire le_rise   = le_s[1] & ~le_s[2];

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sclk_s     <= 3'h0;
            data_s     <= 2'h0;
            le_s       <= 3'h0;
            shift      <= `IFSC_RST_WORD;
            word       <= `IFSC_RST_WORD;
            word_valid <= 1'b0;
        end else begin
            sclk_s     <= {sclk_s[1:0], sclk_pin};
            data_s     <= {data_s[0], serial_data_pin};
            le_s       <= {le_s[1:0], latch_strobe};
            if (sclk_rise) begin
                shift <= {shift[WORD_W-2:0], data_s[1]};
            end
            word_valid <= le_rise;
            if (le_rise) begin
                word <= shift;
            end
        end
    end

endmodule

`default_nettype wire

// ==== hw/ifsc_ref_div.sv ====
/*
 * Reference divider: one output pulse per RATIO input ticks.
 * Assumes ticks are one-cycle enables on sys_clk; ratio 0 acts as 1.
 */
`timescale 1ns/1ps
`default_nettype none

module ifsc_ref_div #(
    parameter int DIV_W = 15
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // control
    input  wire logic             tick,
    input  wire logic             hold,
    input  wire logic [DIV_W-1:0] ratio,
    // phase-detector clock enable
    output logic                  pfd_tick
);

    logic [DIV_W-1:0] count;

    wire last = (count >= ratio - DIV_W'(1)) | (ratio == '0);

    always_ff @(posedge sys_clk) begin
        if (!rst_n || hold) begin
            count    <= '0;
            pfd_tick <= 1'b0;
        end else begin
            pfd_tick <= tick & last;
            if (tick) begin
                count <= last ? '0 : count + DIV_W'(1);
            end
        end
    end

endmodule

`default_nettype wire

// ==== hw/ifsc_top.sv ====
/*
 * IF synthesizer control and RF phase resync: word decode, power-up
 * tracking, IF control outputs, reference paths, resync delay and the
 * division relations. Assumes the reference input is a slow pin,
 * below a quarter of sys_clk, sampled here like the serial pins.
 */
`timescale 1ns/1ps
`default_nettype none

module ifsc_top import ifsc_pkg::*; #(
    parameter int WORD_W   = `IFSC_WORD_W,
    parameter int IF_DIV_W = 15,
    parameter int RF_DIV_W = 4
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // serial port pins
    input  wire logic        sclk_pin,
    input  wire logic        serial_data_pin,
    input  wire logic        latch_strobe,
    // reference input pin
    input  wire logic        ref_in_pin,
    // if control state
    output ifsc_if_ctrl_t    if_ctrl,
    output logic             if_powered_down,
    output logic             rf_powered_down,
    output logic             if_counter_hold,
    output logic             if_cp_three_state,
    output logic             if_lock_detect_reset,
    // phase-detector clock enables
    output logic             if_pfd_tick,
    output logic             rf_pfd_tick,
    // phase resync
    output logic             rf_resync,
    // division relations
    output logic [19:0]      if_n_ratio,
    output logic [23:0]      rf_n_scaled,
    output logic [11:0]      rf_mod
);

    // =========================================================
    // serial input register
    // =========================================================
    // keeps shifting and latching through any power-down
    logic [WORD_W-1:0] word;
    logic              word_valid;

    ifsc_serial_rx #(
        .WORD_W          (WORD_W)
    ) u_rx (
        .sys_clk         (sys_clk),
        .rst_n           (rst_n),
        .sclk_pin        (sclk_pin),
        .serial_data_pin (serial_data_pin),
        .latch_strobe    (latch_strobe),
        .word            (word),
        .word_valid      (word_valid)
    );

    // =========================================================
    // word decode
    // =========================================================
    // the low three bits name the latch; address 7 names none and is
    // dropped without touching any stored word
    function automatic logic hit(input logic [WORD_W-1:0] w,
                                 input logic [2:0]        addr);
        hit = (w[2:0] == addr);
    endfunction

    wire wr_if_ctl = word_valid & hit(word, `IFSC_ADDR_IF_CTL);
    wire wr_if_ref = word_valid & hit(word, `IFSC_ADDR_IF_REF);
    wire wr_if_n   = word_valid & hit(word, `IFSC_ADDR_IF_N);
    wire wr_master = word_valid & hit(word, `IFSC_ADDR_MASTER);
    wire wr_rf_ctl = word_valid & hit(word, `IFSC_ADDR_RF_CTL);
    wire wr_rf_frc = word_valid & hit(word, `IFSC_ADDR_RF_FRC);
    wire wr_rf_int = word_valid & hit(word, `IFSC_ADDR_RF_INT);

    // =========================================================
    // word storage
    // =========================================================
    // contents are never cleared by power-down, only by reset
    // one latch per address; a word lands the cycle after word_valid
    logic [WORD_W-1:0] if_control_word;
    logic [WORD_W-1:0] if_reference_divider_word;
    logic [WORD_W-1:0] if_n_divider_word;
    logic [WORD_W-1:0] master_word;
    logic [WORD_W-1:0] rf_control_word;
    logic [WORD_W-1:0] rf_fraction_word;
    logic [WORD_W-1:0] rf_integer_word;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            if_control_word           <= `IFSC_RST_WORD;
            if_reference_divider_word <= `IFSC_RST_WORD;
            if_n_divider_word         <= `IFSC_RST_WORD;
            master_word               <= `IFSC_RST_WORD;
            rf_control_word           <= `IFSC_RST_WORD;
            rf_fraction_word          <= `IFSC_RST_WORD;
            rf_integer_word           <= `IFSC_RST_WORD;
        end else begin
            if (wr_if_ctl) if_control_word           <= word;
            if (wr_if_ref) if_reference_divider_word <= word;
            if (wr_if_n)   if_n_divider_word         <= word;
            if (wr_master) master_word               <= word;
            if (wr_rf_ctl) rf_control_word           <= word;
            if (wr_rf_frc) rf_fraction_word          <= word;
            if (wr_rf_int) rf_integer_word           <= word;
        end
    end

    // =========================================================
    // power-up tracking
    // =========================================================
    // reset stands in for power being applied; flags only ever set,
    // one per word, in address order from if control down to rf integer
    logic [6:0] written;
    logic [6:0] next_written;

    assign next_written = written | {wr_if_ctl, wr_if_ref, wr_if_n,
                                     wr_master, wr_rf_ctl, wr_rf_frc,
                                     wr_rf_int};

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            written <= 7'h00;
        end else begin
            written <= next_written;
        end
    end

    // the master word is shared: it counts toward both sides
    // if needs 6,5,4,3
    wire if_ready = &written[6:3];
    wire rf_ready = &written[3:0];

    // =========================================================
    // if control fields
    // =========================================================
    ifsc_if_ctrl_t ctrl_dec;

    assign ctrl_dec.counter_reset  = if_control_word[`IFSC_IFC_CNT_RST];
    assign ctrl_dec.cp_three_state = if_control_word[`IFSC_IFC_CP_TS];
    assign ctrl_dec.power_down     = if_control_word[`IFSC_IFC_PD];
    assign ctrl_dec.pd_polarity    = if_control_word[`IFSC_IFC_POL];
    assign ctrl_dec.cp_current     = if_control_word[`IFSC_IFC_CUR];
    assign ctrl_dec.test_mode      = if_control_word[`IFSC_IFC_TEST];
    assign ctrl_dec.resync_en      = if_control_word[`IFSC_IFC_RS_C]
                                   & if_control_word[`IFSC_IFC_RS_B]
                                   & if_control_word[`IFSC_IFC_RS_A];

    wire if_pd_now = ctrl_dec.power_down | ~if_ready;

    // =========================================================
    // control outputs
    // =========================================================
    // all outputs move on one edge, so power-down is never seen
    // without its side effects, nor the lock-detect reset without it
    // counters held or loaded
    wire next_counter_hold   = ctrl_dec.counter_reset | if_pd_now;
    wire next_cp_three_state = ctrl_dec.cp_three_state | if_pd_now;
    wire next_lock_reset     = if_pd_now;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            if_ctrl              <= '0;
            if_powered_down      <= 1'b1;
            rf_powered_down      <= 1'b1;
            if_counter_hold      <= 1'b1;
            if_cp_three_state    <= 1'b1;
            if_lock_detect_reset <= 1'b1;
        end else begin
            if_ctrl              <= ctrl_dec;
            if_powered_down      <= if_pd_now;
            rf_powered_down      <= ~rf_ready;
            if_counter_hold      <= next_counter_hold;
            if_cp_three_state    <= next_cp_three_state;
            if_lock_detect_reset <= next_lock_reset;
        end
    end

    // =========================================================
    // reference input
    // =========================================================
    // two flops tame the pin, the third holds the previous level for
    // the edge detectors; reset level matches the idle pin
    logic [2:0] ref_s;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ref_s <= 3'h0;
        end else begin
            ref_s <= {ref_s[1:0], ref_in_pin};
        end
    end

    wire ref_rise = ref_s[1] & ~ref_s[2];
    wire ref_fall = ~ref_s[1] & ref_s[2];

    // both edges stand in for a doubled reference; duty cycle matters
    // if doubler select
    wire if_ref_tick = ref_rise |
        (if_reference_divider_word[`IFSC_IFR_DBL] & ref_fall);
    wire rf_ref_tick = ref_rise |
        (rf_control_word[`IFSC_RF_DBL] & ref_fall);

    // counter hold covers power-down too, parking the count at load
    ifsc_ref_div #(
        .DIV_W    (IF_DIV_W)
    ) u_if_div (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .tick     (if_ref_tick),
        .hold     (if_counter_hold),
        .ratio    (if_reference_divider_word[`IFSC_IFR_DIV]),
        .pfd_tick (if_pfd_tick)
    );

    // asleep until the rf side has all of its words
    // rf reference divider
    ifsc_ref_div #(
        .DIV_W    (RF_DIV_W)
    ) u_rf_div (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .tick     (rf_ref_tick),
        .hold     (rf_powered_down),
        .ratio    (rf_control_word[`IFSC_RF_RDIV]),
        .pfd_tick (rf_pfd_tick)
    );

    // =========================================================
    // phase resync delay
    // =========================================================
    ifsc_rs_state_t      rs_state;
    ifsc_rs_state_t      next_rs_state;
    logic [IF_DIV_W-1:0] rs_count;
    logic [IF_DIV_W-1:0] next_rs_count;
    logic                next_resync;

    // a write while disabled starts nothing
    // integer or fraction write
    wire rs_start = ctrl_dec.resync_en & (wr_rf_int | wr_rf_frc);
    // the target is read live: lowering it below the count fires at once
    wire [IF_DIV_W-1:0] rs_target =
        if_reference_divider_word[`IFSC_IFR_DIV];
    wire rs_done = (rs_count >= rs_target);

    always_comb begin
        next_rs_state = rs_state;
        next_rs_count = rs_count;
        next_resync   = 1'b0;
        case (rs_state)
            IFSC_RS_IDLE: begin
                // parked at zero so every restart counts from scratch
                next_rs_count = '0;
            end
            IFSC_RS_COUNT: begin
                // a pending resync is dropped once disabled
                if (!ctrl_dec.resync_en) begin
                    next_rs_state = IFSC_RS_IDLE;
                // count plain reference rises, never doubled
                end else if (rs_done) begin
                    next_resync   = 1'b1;
                    next_rs_state = IFSC_RS_IDLE;
                end else if (ref_rise) begin
                    next_rs_count = rs_count + IF_DIV_W'(1);
                end
            end
            default: begin
                next_rs_state = IFSC_RS_IDLE;
            end
        endcase
        if (rs_start) begin
            next_rs_state = IFSC_RS_COUNT;
            next_rs_count = '0;
            next_resync   = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rs_state  <= IFSC_RS_IDLE;
            rs_count  <= '0;
            rf_resync <= 1'b0;
        end else begin
            rs_state  <= next_rs_state;
            rs_count  <= next_rs_count;
            rf_resync <= next_resync;
        end
    end

    // =========================================================
    // division relations
    // =========================================================
    // prescaler code 0 to 3 selects a ratio of 8, 16, 32 or 64
    function automatic logic [6:0] presc(input logic [1:0] code);
        presc = 7'h08 << code;
    endfunction

    wire [1:0]  if_p_code   = if_n_divider_word[`IFSC_IFN_P];
    wire [12:0] if_b_val    = if_n_divider_word[`IFSC_IFN_B];
    wire [5:0]  if_a_val    = if_n_divider_word[`IFSC_IFN_A];
    wire [11:0] rf_int_val  = rf_integer_word[`IFSC_RF_INT];
    wire [11:0] rf_frac_val = rf_fraction_word[`IFSC_RF_FRAC];
    wire [11:0] rf_mod_val  = master_word[`IFSC_RF_MOD];

    // the widest product, 64 times the largest b, still fits 20 bits
    wire [19:0] if_n_calc =
        20'(presc(if_p_code)) * 20'(if_b_val) + 20'(if_a_val);

    // scaled by the modulus so the fraction stays exact; the host keeps
    // the integer times the modulus inside 24 bits, the rest is dropped
    wire [23:0] rf_n_calc =
        24'(rf_int_val) * 24'(rf_mod_val) + 24'(rf_frac_val);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            if_n_ratio  <= 20'h00000;
            rf_n_scaled <= 24'h000000;
            rf_mod      <= 12'h000;
        end else begin
            if_n_ratio  <= if_n_calc;
            rf_n_scaled <= rf_n_calc;
            rf_mod      <= master_word[`IFSC_RF_MOD];
        end
    end

endmodule

`default_nettype wire

// ==== dv/ifsc_assertions.sv ====
/* Port checker for ifsc_top: power-down side effects, quiet dividers,
   resync pulse shape.
   Assumes it is bound to every ifsc_top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module ifsc_assertions import ifsc_pkg::*; (
    // clock and reset
    input wire logic          sys_clk,
    input wire logic          rst_n,
    // watched outputs
    input wire ifsc_if_ctrl_t if_ctrl,
    input wire logic          if_powered_down,
    input wire logic          rf_powered_down,
    input wire logic          if_counter_hold,
    input wire logic          if_cp_three_state,
    input wire logic          if_lock_detect_reset,
    input wire logic          if_pfd_tick,
    input wire logic          rf_pfd_tick,
    input wire logic          rf_resync
);
    // ====================================================
    // properties
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    property p_hold;
        if_ctrl.counter_reset && $past(if_ctrl.counter_reset)
            |-> if_counter_hold;
    endproperty
    a_hold: assert property (p_hold) else $error("hold missing");
    property p_float;
        if_ctrl.cp_three_state && $past(if_ctrl.cp_three_state)
            |-> if_cp_three_state;
    endproperty
    a_float: assert property (p_float) else $error("pump driven");
    property p_down;
        if_ctrl.power_down && $past(if_ctrl.power_down) |-> if_powered_down;
    endproperty
    a_down: assert property (p_down) else $error("if side up");
    property p_side;
        if_powered_down && $past(if_powered_down)
            |-> if_counter_hold && if_cp_three_state && if_lock_detect_reset;
    endproperty
    a_side: assert property (p_side) else $error("side effect lost");
    property p_if_quiet;
        if_counter_hold && $past(if_counter_hold) |-> !if_pfd_tick;
    endproperty
    a_if_quiet: assert property (p_if_quiet) else $error("if tick");
    property p_rf_quiet;
        rf_powered_down && $past(rf_powered_down) |-> !rf_pfd_tick;
    endproperty
    a_rf_quiet: assert property (p_rf_quiet) else $error("rf tick");
    property p_pulse;
        rf_resync |=> !rf_resync;
    endproperty
    a_pulse: assert property (p_pulse) else $error("long resync");
    property p_rs_en;
        rf_resync |-> if_ctrl.resync_en;
    endproperty
    a_rs_en: assert property (p_rs_en) else $error("resync off");
    property p_up;
        $fell(if_powered_down) |-> !if_ctrl.power_down;
    endproperty
    a_up: assert property (p_up) else $error("early power-up");
endmodule
bind ifsc_top ifsc_assertions i_chk (
    .sys_clk, .rst_n, .if_ctrl, .if_powered_down, .rf_powered_down,
    .if_counter_hold, .if_cp_three_state, .if_lock_detect_reset,
    .if_pfd_tick, .rf_pfd_tick, .rf_resync
);
`default_nettype wire

// ==== dv/ifsc_host_model.sv ====
/* Host side of the three-wire port: shifts one word, then strobes.
   Assumes sys_clk is the bench clock; sclk runs at a ninth of it, below quarter rate. */
`timescale 1ns/1ps
`default_nettype none
module ifsc_host_model (
    // clock
    input  wire logic sys_clk,
    // serial pins
    output var logic  sclk_pin,
    output var logic  serial_data_pin,
    output var logic  latch_strobe
);
    // four cycles a half keeps sclk well inside the sampling limit
    localparam int HALF = 4;
    initial begin
        sclk_pin = 1'b0;
        serial_data_pin = 1'b0;
        latch_strobe = 1'b0;
    end
    task automatic send_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            @(posedge sys_clk);
            serial_data_pin <= w[i];
            repeat (HALF) @(posedge sys_clk);
            sclk_pin <= 1'b1;
            repeat (HALF) @(posedge sys_clk);
            sclk_pin <= 1'b0;
        end
        repeat (HALF) @(posedge sys_clk);
        latch_strobe <= 1'b1;
        // released data line: no keeper, so show the opposite level
        serial_data_pin <= ~w[0];
        repeat (HALF) @(posedge sys_clk);
        latch_strobe <= 1'b0;
        repeat (HALF) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// ==== dv/if_synth_control_and_resync_tb.sv ====
/* Self-checking bench for ifsc_top with a host model and free reference.
   Assumes the checker binds itself; reference period is 8 cycles. */
`timescale 1ns/1ps
`default_nettype none
module if_synth_control_and_resync_tb import ifsc_pkg::*; ;
    logic           sys_clk = 1'b0;
    logic           rst_n = 1'b0;
    logic           ref_in_pin = 1'b0;
    logic           sclk_pin, serial_data_pin, latch_strobe;
    ifsc_if_ctrl_t  if_ctrl;
    logic           if_powered_down, rf_powered_down, if_counter_hold;
    logic           if_cp_three_state, if_lock_detect_reset;
    logic           if_pfd_tick, rf_pfd_tick, rf_resync;
    logic [19:0]    if_n_ratio;
    logic [23:0]    rf_n_scaled;
    logic [11:0]    rf_mod;
    int             bad_count = 0;
    int             compares = 0;
    int             cyc = 0;
    logic [15:0]    lfsr = 16'h0053;

    ifsc_top i_dut (
        .sys_clk, .rst_n, .sclk_pin, .serial_data_pin, .latch_strobe,
        .ref_in_pin, .if_ctrl, .if_powered_down, .rf_powered_down,
        .if_counter_hold, .if_cp_three_state, .if_lock_detect_reset,
        .if_pfd_tick, .rf_pfd_tick, .rf_resync, .if_n_ratio,
        .rf_n_scaled, .rf_mod
    );
    ifsc_host_model i_host (
        .sys_clk, .sclk_pin, .serial_data_pin, .latch_strobe
    );

    // ====================================================
    // clock, reference and hang guard
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        ref_in_pin <= cyc[2];
        if (cyc == 40000) begin
            bad_count = bad_count + 1;
            conclude();
        end
    end

    // ====================================================
    // word builders and expectations
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    // f = {cur, pol, pd, three-state, counter reset}
    function automatic logic [23:0] ifc(input logic [6:0] f, input logic rs);
        return {8'h00, rs, rs, 2'b00, rs, f[6:3], 1'b0, f[2:0],
                `IFSC_ADDR_IF_CTL};
    endfunction
    function automatic logic [23:0] ifr(input logic d, input logic [14:0] r);
        return {5'h00, d, r, `IFSC_ADDR_IF_REF};
    endfunction
    function automatic logic [23:0] ifn(input logic [1:0] p,
                                        input logic [12:0] b,
                                        input logic [5:0] a);
        return {p, b, a, `IFSC_ADDR_IF_N};
    endfunction
    function automatic logic [19:0] exp_n(input logic [1:0] p,
                                          input logic [12:0] b,
                                          input logic [5:0] a);
        return (20'h00008 << p) * b + a;
    endfunction
    function automatic logic [23:0] exp_rf(input logic [11:0] i,
                                           input logic [11:0] f,
                                           input logic [11:0] m);
        return i * m + f;
    endfunction

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [23:0] w);
        i_host.send_word(w);
        repeat (8) @(posedge sys_clk);
        #1;
    endtask
    // cycles until the chosen output is seen high, 900 means never
    // sel 0 if_pfd_tick, 1 rf_resync, 2 rf_pfd_tick
    task automatic till(input logic [1:0] sel, output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while (n < 900 && !(sel[1] ? rf_pfd_tick
                                : sel[0] ? rf_resync : if_pfd_tick));
    endtask
    task automatic conclude();
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ====================================================
    // main sequence
    initial begin
        logic [15:0] b, a, f;
        logic [19:0] nexp;
        int          n;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk({if_powered_down, rf_powered_down, if_counter_hold,
             if_cp_three_state, if_lock_detect_reset}, 24'h00001f);
        wr(ifc(7'h00, 1'b0));
        wr(ifr(1'b0, 15'h0003));
        wr(ifn(2'h1, 13'h00a8, 6'h0c));
        chk(if_powered_down, 1'b1);
        wr({1'b0, 12'h041, 8'h00, `IFSC_ADDR_MASTER});
        chk({if_powered_down, rf_powered_down}, 2'b01);
        wr({2'b00, 1'b0, 4'h2, 14'h0000, `IFSC_ADDR_RF_CTL});
        wr({9'h000, 12'h01e, `IFSC_ADDR_RF_FRC});
        chk(rf_powered_down, 1'b1);
        wr({9'h000, 12'h08a, `IFSC_ADDR_RF_INT});
        chk(rf_powered_down, 1'b0);
        chk(rf_n_scaled, exp_rf(12'h08a, 12'h01e, 12'h041));
        chk(rf_mod, 12'h041);
        chk(if_n_ratio, exp_n(2'h1, 13'h00a8, 6'h0c));
        // rf rate: divider of two, doubler off then on
        for (int k = 0; k < 2; k++) begin
            wr({2'b00, k[0], 4'h2, 14'h0000, `IFSC_ADDR_RF_CTL});
            till(2'h2, n);
            till(2'h2, n);
            chk(n, k[0] ? 8 : 16);
        end
        for (int k = 0; k < 4; k++) begin
            b = rnd();
            a = rnd();
            nexp = exp_n(k[1:0], b[12:0], a[5:0]);
            wr(ifn(k[1:0], b[12:0], a[5:0]));
            chk(if_n_ratio, nexp);
        end
        for (int k = 0; k < 8; k++) begin
            f = rnd();
            wr(ifc(f[6:0], 1'b0));
            chk(if_ctrl, {3'b000, f[6:0]});
            chk({rf_powered_down, if_counter_hold, if_cp_three_state,
                 if_lock_detect_reset, if_powered_down},
                {1'b0, f[0] | f[2], f[1] | f[2], f[2], f[2]});
            chk(if_n_ratio, nexp);
        end
        wr({f[15:0], 5'h00, 3'h7});
        chk(if_ctrl, {3'b000, f[6:0]});
        wr(ifc(7'h00, 1'b0));
        for (int k = 0; k < 4; k++) begin
            wr(ifr(k[1], k[0] ? 15'h0001 : 15'h0003));
            till(1'b0, n);
            till(1'b0, n);
            chk(n, (k[0] ? 1 : 3) * (k[1] ? 4 : 8));
        end
        wr(ifr(1'b0, 15'h0041));
        wr(ifc(7'h00, 1'b1));
        chk(if_ctrl.resync_en, 1'b1);
        wr({9'h000, 12'h08b, `IFSC_ADDR_RF_INT});
        till(1'b1, n);
        chk(n >= 500 && n <= 540, 1'b1);
        wr({9'h000, 12'h08a, `IFSC_ADDR_RF_INT});
        wr({9'h000, 12'h01f, `IFSC_ADDR_RF_FRC});
        till(1'b1, n);
        chk(n >= 500 && n <= 540, 1'b1);
        // a pending count must die when resync is disabled
        wr({9'h000, 12'h08a, `IFSC_ADDR_RF_INT});
        wr(ifc(7'h00, 1'b1) & 24'hfff7ff);
        chk(if_ctrl.resync_en, 1'b0);
        wr({9'h000, 12'h08b, `IFSC_ADDR_RF_INT});
        till(1'b1, n);
        chk(n, 900);
        conclude();
    end
endmodule
`default_nettype wire
